//--- src/sbc_system_bus_control_regs.sv
// System bus control register bank with chip-select, wait and bus-release pin steering
// Overview of operation
// RULE_01: Bus-expansion bit picks expanded or single chip; external-ROM mode always expanded.
// RULE_02: Set chip-select enable bit routes active-low chip select to its shared pin.
// RULE_03: Cleared enable bit, or single chip mode, leaves pin as port output.
// RULE_04: Eight-bit read/write stack page register supplies upper stack address page.
// RULE_05: Software keeps stack page 0 in single chip, 0 to 27H expanded.
// RULE_06: Bus-release enable turns shared pins into request input and acknowledge output.
// RULE_07: Wait code inserts twice its value in half-clock states, zero to fourteen.
// RULE_08: Clock select bit runs the CPU from fast oscillator when set.
// RULE_09: Oscillator control bit turns the fast oscillator on when set.
// RULE_10: All interrupts blocked until both first and stack page registers written.
// RULE_11: Internal-ROM reset clears all bits except spare bits 5 and 4.
// RULE_12: External-ROM reset sets expansion, chip-select 0 and spare bits 5, 4.
// RULE_13: Wait states go between T3 and T4, external fast-clock accesses only.
// RULE_14: Enabled chip select asserts only during its external area access.
// RULE_15: Stack page write blocks interrupts for one more instruction period.
// RULE_16: Spare bits store and read back written values without other effect.
`timescale 1ns/10ps
module sbc_system_bus_control_regs
   import sbc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        extRomMode,
   input  wire logic [15:0] regAddr,
   input  wire logic [7:0]  regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [7:0]  regRdata,
   input  wire logic [3:0]  chipSelArea,
   input  wire logic        extAccess,
   input  wire logic        busT3Done,
   output logic             busWaitHold,
   input  wire logic        instrEnd,
   output logic             intBlock,
   output logic      [7:0]  stackPage,
   output logic             busExpanded,
   input  wire logic [3:0]  chipSelPortData,
   output logic      [3:0]  chipSelSharedPorts,
   input  wire logic        busReqSharedInput,
   output logic             busReleaseRequest,
   output logic             portInData,
   input  wire logic        busAckLow,
   input  wire logic        busAckPortData,
   output logic             busAckSharedOutput,
   output logic             cpuClockSelect,
   output logic             fastOscEnable
);
   // -----------------------------------------------------------------
   // Reset release and strap capture
   // -----------------------------------------------------------------
   logic       rstMeta_r;
   logic       rstSync_r;
   logic       strapDone_r;
   logic       mpuMode_r;
   logic [2:0] reqSync_r;
   logic       reqStable_r;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstMeta_r <= 1'b0;
         rstSync_r <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSync_r <= rstMeta_r;
      end
   end

   // Strap sampled in the first cycle after release
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         strapDone_r <= 1'b0;
         mpuMode_r   <= 1'b0;
      end else if (!strapDone_r) begin
         strapDone_r <= 1'b1;
         mpuMode_r   <= extRomMode;
      end
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   logic [7:0] busCtrl_r;
   logic [7:0] stackPage_r;
   logic [7:0] relCtrl_r;
   logic       wrBus;
   logic       wrPage;
   logic       wrRel;

   always_comb begin
      wrBus  = 1'b0;
      wrPage = 1'b0;
      wrRel  = 1'b0;
      if (regWr && regAddr == SBC_BUS_CTRL_OFS) begin
         wrBus = 1'b1;
      end else if (regWr && regAddr == SBC_STACK_PAGE_OFS) begin
         wrPage = 1'b1;
      end else if (regWr && regAddr == SBC_REL_CTRL_OFS) begin
         wrRel = 1'b1;
      end
   end

   // Mode-dependent reset value applied once the strap is known
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         busCtrl_r <= SBC_BUS_CTRL_RST_MCU; // [RULE_11]
      end else if (!strapDone_r) begin
         busCtrl_r <= extRomMode ? SBC_BUS_CTRL_RST_MPU : SBC_BUS_CTRL_RST_MCU; // [RULE_12]
      end else if (wrBus) begin
         busCtrl_r <= regWdata; // [RULE_16]
      end
   end

   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         stackPage_r <= SBC_STACK_PAGE_RST;
      end else if (wrPage) begin
         stackPage_r <= regWdata; // [RULE_04]
      end
   end

   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         relCtrl_r <= SBC_REL_CTRL_RST;
      end else if (wrRel) begin
         relCtrl_r <= regWdata;
      end
   end

   // -----------------------------------------------------------------
   // Read port
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         regRdata <= 8'h00;
      end else if (!regRd) begin
         regRdata <= 8'h00;
      end else if (regAddr == SBC_BUS_CTRL_OFS) begin
         regRdata <= busCtrl_r;
      end else if (regAddr == SBC_STACK_PAGE_OFS) begin
         regRdata <= stackPage_r;
      end else if (regAddr == SBC_REL_CTRL_OFS) begin
         regRdata <= relCtrl_r;
      end else begin
         regRdata <= 8'h00;
      end
   end

   // -----------------------------------------------------------------
   // Interrupt blocking
   // -----------------------------------------------------------------
   logic       seenBus_r;
   logic       seenPage_r;
   logic [3:0] guardCnt_r;

   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         seenBus_r  <= 1'b0;
         seenPage_r <= 1'b0;
      end else begin
         if (wrBus) begin
            seenBus_r <= 1'b1;
         end
         if (wrPage) begin
            seenPage_r <= 1'b1;
         end
      end
   end

   // Counts instruction ends after a stack page write
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         guardCnt_r <= 4'h0;
      end else if (wrPage) begin
         guardCnt_r <= SBC_SP_GUARD_INSTR + 4'h1; // [RULE_15]
      end else if (instrEnd && guardCnt_r != 4'h0) begin
         guardCnt_r <= guardCnt_r - 4'h1;
      end
   end

   assign intBlock = !(seenBus_r && seenPage_r) || wrPage || guardCnt_r != 4'h0; // [RULE_10] [RULE_15]

   // -----------------------------------------------------------------
   // Bus mode, chip selects and pin steering
   // -----------------------------------------------------------------
   logic [3:0] csOn;

   assign busExpanded = mpuMode_r || busCtrl_r[SBC_BUS_EXP_BIT]; // [RULE_01]
   assign stackPage   = stackPage_r;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         csOn[i] = busExpanded && busCtrl_r[SBC_CS_EN_LSB + i]; // [RULE_02] [RULE_03]
         chipSelSharedPorts[i] = csOn[i] ? !(chipSelArea[i] && extAccess) // [RULE_14]
                                         : chipSelPortData[i]; // [RULE_03]
      end
   end

   logic relEn;
   assign relEn = relCtrl_r[SBC_REL_EN_BIT];

   // Request pin through three flops; change taken when last two agree
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         reqSync_r   <= 3'b111;
         reqStable_r <= 1'b1;
      end else begin
         reqSync_r <= {reqSync_r[1:0], busReqSharedInput};
         if (reqSync_r[1] == reqSync_r[2]) begin
            reqStable_r <= reqSync_r[2];
         end
      end
   end

   assign busReleaseRequest  = relEn && !reqStable_r; // [RULE_06]
   assign portInData         = reqStable_r;
   assign busAckSharedOutput = relEn ? busAckLow : busAckPortData; // [RULE_06]

   assign cpuClockSelect = relCtrl_r[SBC_CLK_SEL_BIT]; // [RULE_08]
   assign fastOscEnable  = relCtrl_r[SBC_OSC_ON_BIT];  // [RULE_09]

   // -----------------------------------------------------------------
   // Wait insertion between T3 and T4
   // -----------------------------------------------------------------
   sbc_phase_type phase_r;
   logic [3:0]    waitCnt_r;
   logic [3:0]    waitStates;

   assign waitStates = {relCtrl_r[SBC_WAIT_LSB +: 3], 1'b0}; // [RULE_07]

   // One half-clock state per clk cycle
   always_ff @(posedge clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         phase_r   <= SBC_PH_IDLE;
         waitCnt_r <= 4'h0;
      end else begin
         case (phase_r)
            SBC_PH_IDLE: begin
               if (busT3Done && extAccess && cpuClockSelect && waitStates != 4'h0) begin // [RULE_13]
                  phase_r   <= SBC_PH_WAIT;
                  waitCnt_r <= waitStates - 4'h2; // [RULE_07]
               end
            end
            SBC_PH_WAIT: begin
               if (waitCnt_r == 4'h0) begin
                  phase_r <= SBC_PH_LAST;
               end else begin
                  waitCnt_r <= waitCnt_r - 4'h1;
               end
            end
            SBC_PH_LAST: begin
               phase_r <= SBC_PH_IDLE;
            end
            default: begin
               phase_r <= SBC_PH_IDLE;
            end
         endcase
      end
   end

   assign busWaitHold = (phase_r == SBC_PH_WAIT) ||
                        (phase_r == SBC_PH_IDLE && busT3Done && extAccess &&
                         cpuClockSelect && waitStates != 4'h0); // [RULE_13]

endmodule

//--- src/sbc_pkg.sv
// Package with register map, field positions and reset values of the system bus control bank
package sbc_pkg;
   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [15:0] SBC_BUS_CTRL_OFS   = 16'hff00;
   localparam logic [15:0] SBC_STACK_PAGE_OFS = 16'hff01;
   localparam logic [15:0] SBC_REL_CTRL_OFS   = 16'hff02;
   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int SBC_BUS_EXP_BIT   = 6;
   localparam int SBC_CS_EN_LSB     = 0;
   localparam int SBC_REL_EN_BIT    = 7;
   localparam int SBC_WAIT_LSB      = 4;
   localparam int SBC_CLK_SEL_BIT   = 3;
   localparam int SBC_OSC_ON_BIT    = 2;
   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] SBC_BUS_CTRL_RST_MCU = 8'h30;
   localparam logic [7:0] SBC_BUS_CTRL_RST_MPU = 8'h71;
   localparam logic [7:0] SBC_STACK_PAGE_RST   = 8'h00;
   localparam logic [7:0] SBC_REL_CTRL_RST     = 8'h00;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam logic [3:0] SBC_SP_GUARD_INSTR = 4'h1;
   // Access phase of the bus cycle
   typedef enum logic [2:0] {
      SBC_PH_IDLE = 3'b001,
      SBC_PH_WAIT = 3'b010,
      SBC_PH_LAST = 3'b100
   } sbc_phase_type;
endpackage

//--- bench/sbc_ext_master.sv
// Model of an external master asking for bus release
`timescale 1ns/10ps
module sbc_ext_master (
   input  wire logic clk,
   input  wire logic want,
   output logic      busReqN
);
   // Request pin is active low and idles high
   always_ff @(posedge clk) busReqN <= ~want;
endmodule

//--- bench/sbc_regs_props.sv
// Checker of the system bus control register bank
`timescale 1ns/10ps
module sbc_regs_props
   import sbc_pkg::*;
(
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        extRomMode,
   input wire logic [15:0] regAddr,
   input wire logic [7:0]  regWdata,
   input wire logic        regWr,
   input wire logic [3:0]  chipSelArea,
   input wire logic        extAccess,
   input wire logic        busT3Done,
   input wire logic        busWaitHold,
   input wire logic        intBlock,
   input wire logic [7:0]  stackPage,
   input wire logic        busExpanded,
   input wire logic [3:0]  chipSelPortData,
   input wire logic [3:0]  chipSelSharedPorts,
   input wire logic        busAckLow,
   input wire logic        busAckPortData,
   input wire logic        busAckSharedOutput
);
   // ----
   // Shadow registers
   // ----
   logic [7:0] busCtl_r, relCtl_r;
   logic [2:0] live_r;
   logic [1:0] wrote_r;
   wire        wB = regWr && (regAddr == SBC_BUS_CTRL_OFS);
   wire        wS = regWr && (regAddr == SBC_STACK_PAGE_OFS);
   wire        wR = regWr && (regAddr == SBC_REL_CTRL_OFS);
   wire  [7:0] busEff = wrote_r[0] ? busCtl_r :
                        (extRomMode ? SBC_BUS_CTRL_RST_MPU : SBC_BUS_CTRL_RST_MCU);
   wire  [3:0] csEn = busEff[3:0];
   wire        waitOn = extAccess && relCtl_r[3] && (relCtl_r[6:4] != 3'h0);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         {busCtl_r, relCtl_r, wrote_r, live_r} <= '0;
      end else begin
         live_r  <= live_r + {2'h0, ~live_r[2]};
         wrote_r <= wrote_r | {wS, wB};
         if (wB) busCtl_r <= regWdata;
         if (wR) relCtl_r <= regWdata;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst || !live_r[2]);
   sequence holdSeven;
      busWaitHold [*7];
   endsequence
   chk_bus_mode: assert property (busExpanded == (extRomMode | busEff[6]))
      else $error("bus mode wrong");
   chk_cs_route: assert property (busExpanded |-> chipSelSharedPorts ==
      ((~(chipSelArea & {4{extAccess}}) & csEn) | (chipSelPortData & ~csEn)))
      else $error("chip select wrong");
   chk_cs_port: assert property (!busExpanded |-> chipSelSharedPorts == chipSelPortData)
      else $error("port data wrong");
   chk_page_write: assert property (wS |=> stackPage == $past(regWdata))
      else $error("stack page wrong");
   chk_rel_ack: assert property (busAckSharedOutput ==
      (relCtl_r[7] ? busAckLow : busAckPortData)) else $error("ack pin wrong");
   chk_wait_none: assert property (busT3Done && !waitOn |-> !busWaitHold)
      else $error("wait not expected");
   chk_wait_long: assert property (busT3Done && waitOn && relCtl_r[6:4] == 3'h7
      |-> holdSeven ##1 holdSeven ##1 !busWaitHold) else $error("wait length wrong");
   chk_int_open: assert property (wrote_r != 2'h3 |-> intBlock)
      else $error("interrupt open early");
   chk_sp_guard: assert property (wS |-> intBlock ##1 intBlock)
      else $error("guard missing");
endmodule
bind sbc_system_bus_control_regs sbc_regs_props u_props (.clk, .nrst, .extRomMode,
   .regAddr, .regWdata, .regWr, .chipSelArea, .extAccess, .busT3Done, .busWaitHold,
   .intBlock, .stackPage, .busExpanded, .chipSelPortData, .chipSelSharedPorts,
   .busAckLow, .busAckPortData, .busAckSharedOutput);

//--- bench/sbc_system_bus_control_regs_test.sv
// Self-checking bench of the system bus control register bank
`timescale 1ns/10ps
module sbc_system_bus_control_regs_test
   import sbc_pkg::*;
;
   logic        clk, nrst, extRomMode, regWr, regRd, extAccess, busT3Done, instrEnd, want;
   logic        busAckLow, busAckPortData, busReqSharedInput, busWaitHold, intBlock, portIn;
   logic        busExpanded, busReleaseRequest, busAckSharedOutput, cpuClockSelect, fastOscEnable;
   logic [15:0] regAddr, a;
   logic [7:0]  regWdata, regRdata;
   logic [7:0]  m [4];
   logic [3:0]  chipSelArea, chipSelPortData, chipSelSharedPorts;
   int          num_errors, check_count, n;
   sbc_system_bus_control_regs u_dut (.clk, .nrst, .extRomMode, .regAddr, .regWdata, .regWr,
      .regRd, .regRdata, .chipSelArea, .extAccess, .busT3Done, .busWaitHold, .instrEnd,
      .intBlock, .stackPage(), .busExpanded, .chipSelPortData, .chipSelSharedPorts,
      .busReqSharedInput, .busReleaseRequest, .portInData(portIn), .busAckLow, .busAckPortData,
      .busAckSharedOutput, .cpuClockSelect, .fastOscEnable);
   sbc_ext_master u_ext (.clk, .want, .busReqN(busReqSharedInput));
   // ----
   // Tasks
   // ----
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done;
      if (num_errors == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   function automatic logic [7:0] exp_rd(input logic [15:0] ad);
      return (ad[15:2] == 14'h3fc0 && ad[1:0] != 2'h3) ? m[ad[1:0]] : 8'h00;
   endfunction
   task automatic rst(input logic mpu);
      nrst <= 1'b0;
      extRomMode <= mpu;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      m = '{mpu ? 8'h71 : 8'h30, 8'h00, 8'h00, 8'h00};
      repeat (4) @(posedge clk);
   endtask
   task automatic wr(input logic [15:0] ad, input logic [7:0] d);
      {regAddr, regWdata, regWr} <= {ad, d, 1'b1};
      @(posedge clk);
      regWr <= 1'b0;
      if (exp_rd(ad) !== 8'h00 || ad[15:2] == 14'h3fc0 && ad[1:0] != 2'h3) m[ad[1:0]] = d;
      @(posedge clk);
   endtask
   task automatic rd(input logic [15:0] ad, input string what);
      {regAddr, regRd} <= {ad, 1'b1};
      @(posedge clk);
      regRd <= 1'b0;
      #1 chk(regRdata, exp_rd(ad), what);
      @(posedge clk);
   endtask
   task automatic cyc(input logic [2:0] c, input logic fast);
      wr(SBC_REL_CTRL_OFS, {1'b0, c, fast, 1'b1, 2'h0});
      chk(cpuClockSelect, fast, "clock select");
      chk(fastOscEnable, 1'b1, "osc enable");
      {extAccess, busT3Done} <= 2'h3;
      n = 0;
      repeat (18) begin
         #1 if (busWaitHold === 1'b1) n++;
         @(posedge clk);
         busT3Done <= 1'b0;
      end
      chk(8'(n), fast ? {4'h0, c, 1'b0} : 8'h00, "wait states");
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #60000;
      num_errors++;
      test_done;
   end
   initial begin
      {nrst, extRomMode, regWr, regRd, extAccess, busT3Done, instrEnd, want} = '0;
      {regAddr, regWdata, chipSelArea, chipSelPortData, busAckLow, busAckPortData} = '0;
      void'($urandom(78306));
      rst(1'b0);
      for (int i = 0; i < 4; i++) rd(16'hff00 + 16'(i), "reset value");
      chipSelPortData <= 4'($urandom);
      wr(SBC_BUS_CTRL_OFS, 8'h0f);
      chk(chipSelSharedPorts, chipSelPortData, "single chip pins");
      chk(intBlock, 1'b1, "block one write");
      wr(SBC_STACK_PAGE_OFS, 8'h17);
      for (int i = 0; i < 2; i++) begin
         chk(intBlock, 1'b1, "guard");
         instrEnd <= 1'b1;
         @(posedge clk);
         instrEnd <= 1'b0;
         @(posedge clk);
      end
      chk(intBlock, 1'b0, "unblocked");
      repeat (24) begin
         a = 16'hff00 + 16'($urandom_range(3));
         wr(a, (a == SBC_STACK_PAGE_OFS) ? 8'($urandom_range(39)) : 8'($urandom));
         rd(16'hff00 + 16'($urandom_range(3)), "readback");
         chk(busExpanded, m[0][6], "expanded");
      end
      wr(SBC_BUS_CTRL_OFS, 8'h4a);
      for (int i = 0; i < 4; i++) begin
         {chipSelArea, extAccess} <= {4'h1 << i, 1'b1};
         @(posedge clk);
         #1 chk(chipSelSharedPorts, (chipSelPortData & 4'h5) | (~chipSelArea & 4'ha), "cs");
         extAccess <= 1'b0;
         @(posedge clk);
         #1 chk(chipSelSharedPorts, (chipSelPortData & 4'h5) | 4'ha, "cs internal");
      end
      chipSelArea <= 4'h0;
      for (int c = 0; c < 8; c++) cyc(3'(c), 1'b1);
      cyc(3'h7, 1'b0);
      {busAckLow, busAckPortData, want} <= 3'b011;
      wr(SBC_REL_CTRL_OFS, 8'h80);
      repeat (8) @(posedge clk);
      chk(busReleaseRequest, 1'b1, "request");
      chk(busAckSharedOutput, 1'b0, "ack");
      chk(portIn, 1'b0, "port input");
      wr(SBC_REL_CTRL_OFS, 8'h00);
      chk(busReleaseRequest, 1'b0, "no request");
      chk(busAckSharedOutput, 1'b1, "port");
      rst(1'b1);
      rd(SBC_BUS_CTRL_OFS, "mpu reset");
      wr(SBC_BUS_CTRL_OFS, 8'h00);
      chk(busExpanded, 1'b1, "mpu expanded");
      test_done;
   end
endmodule
